// file: logic/motor_pwm_fault_trigger.sv
// motor pwm time base, fault protection, update lock and a/d trigger
////////////////////////////////////////////////////////////////////////////////
// How it works
// - each output pin has a fault state bit; clear means inactive, set active
// - fault active and inactive levels follow the pin's configured polarity
// - latched mode: low fault input forces outputs until input high and flag cleared
// - latched release happens at the next period or half-period boundary
// - cycle-by-cycle mode forces only while low; release at next boundary
// - fault control bit 7 selects latched or cycle-by-cycle handling
// - while update lock is set no duty or period buffer reaches active use
// - trigger raised when time base counter equals the trigger compare value
// - in up/down modes compare bit 15 picks upward or downward count
// - four-bit postscaler gives ratios one-in-one to one-in-sixteen
// - postscaler count cleared by trigger compare write and by reset
// - a low fault input during sleep raises a waking interrupt
// - idle stop bit set halts the time base while the processor idles
// - fault input forces no pin when no pair enable bit is set; the fault flag still sets
// - boundary is zero, and in centre modes also the period match
// - high polarity drives all high pins, low polarity all low pins
module motor_pwm_fault_trigger
   import motor_pwm_pkg::*;
#(
   parameter int PAIRS = 3
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic [11:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic FAULT_INPUT_N,
   input wire logic HIGH_SIDE_POLARITY,
   input wire logic LOW_SIDE_POLARITY,
   input wire logic SLEEP,
   input wire logic IDLE,
   output logic [2*PAIRS-1:0] PWM_OUT,
   output logic [2*PAIRS-1:0] PWM_OE,
   output logic ADC_TRIGGER,
   output logic IRQ,
   output logic WAKE
);
   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [15:0] tbcon;
      logic [14:0] cnt;
      logic dir;
      logic [14:0] per_buf;
      logic [14:0] per_act;
      logic [15:0] cmp;
      logic [15:0] con1;
      logic [15:0] con2;
      logic [15:0] dtcon;
      logic [15:0] fltcon;
      logic [15:0] ovd;
      logic [PAIRS-1:0][15:0] duty_buf;
      logic [PAIRS-1:0][15:0] duty_act;
      logic sync1;
      logic sync2;
      logic sync3;
      logic fault_act;
      logic [3:0] post_cnt;
      logic [2:0] status;
      logic [2:0] mask;
      logic trig;
      logic [2*PAIRS-1:0] pin_lvl;
      logic [31:0] rdata;
      logic rvalid;
   } state_t;

   state_t s;
   state_t n;
   logic run;
   logic [1:0] mode;
   logic centre;
   logic at_zero;
   logic at_per;
   logic boundary;
   logic lock;
   logic fault_low;
   logic fault_fell;
   logic en_any;
   logic cycle_mode;
   logic match;
   logic wr;
   logic [9:0] idx;
   logic [2:0] clr;
   logic [15:0] rd_mux;
   logic [2*PAIRS-1:0] act;
   logic [15:0] wd;
   logic [2:0] ev;

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                        input logic [1:0] be);
      merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      n = s;
      ev = 3'h0;
      idx = AVS_ADDRESS[11:2];
      wd = AVS_WRITEDATA[15:0];
      wr = AVS_WRITE;
      mode = s.tbcon[TB_MODE_LSB+:2];
      centre = mode[0];
      lock = s.con2[UPDATE_LOCK_BIT];
      run = s.tbcon[TIME_BASE_ON_BIT] && !(IDLE && s.tbcon[IDLE_STOP_BIT]);
      at_zero = (s.cnt == 15'h0000);
      at_per = (s.cnt == s.per_act);
      boundary = at_zero || (centre && at_per);

      // time base
      if (run) begin
         if (at_zero) begin
            ev[EV_PERIOD] = 1'b1;
         end
         case (mode)
            MODE_FREE: begin
               n.cnt = (s.cnt >= s.per_act) ? 15'h0000 : s.cnt + 15'h0001;
            end
            MODE_SINGLE: begin
               if (s.cnt >= s.per_act) begin
                  n.cnt = 15'h0000;
                  n.tbcon[TIME_BASE_ON_BIT] = 1'b0;
               end else begin
                  n.cnt = s.cnt + 15'h0001;
               end
            end
            default: begin
               if (!s.dir) begin
                  if (s.cnt >= s.per_act) begin
                     n.dir = 1'b1;
                     n.cnt = at_zero ? 15'h0000 : s.cnt - 15'h0001;
                  end else begin
                     n.cnt = s.cnt + 15'h0001;
                  end
               end else if (at_zero) begin
                  n.dir = 1'b0;
                  n.cnt = (s.per_act == 15'h0000) ? 15'h0000 : 15'h0001;
               end else begin
                  n.cnt = s.cnt - 15'h0001;
               end
            end
         endcase
      end

      // buffered values move only while unlocked
      if (!lock && (!run || at_zero)) begin
         n.per_act = s.per_buf;
      end
      if (!lock && (!run || at_zero || (mode == MODE_DOUBLE && at_per))) begin
         n.duty_act = s.duty_buf;
      end

      // fault input; only the second stage and later are looked at
      n.sync1 = FAULT_INPUT_N;
      n.sync2 = s.sync1;
      n.sync3 = s.sync2;
      fault_low = !s.sync2;
      fault_fell = s.sync3 && !s.sync2;
      en_any = |s.fltcon[FAULT_PAIR_ENABLE_LSB+:PAIRS];
      cycle_mode = s.fltcon[FAULT_MODE_SELECT_BIT];
      if (!en_any) begin
         n.fault_act = 1'b0;
      end else if (fault_low) begin
         n.fault_act = 1'b1;
      end else if (s.fault_act && boundary && (cycle_mode || !s.status[EV_FAULT])) begin
         n.fault_act = 1'b0;
      end

      // trigger compare and postscaler
      match = run && (s.cnt == s.cmp[14:0]) &&
              (!centre || (s.dir == s.cmp[TRIGGER_DIRECTION_BIT]));
      n.trig = 1'b0;
      // a counter parked on the compare value must not stretch the pulse
      if (match && !s.trig) begin
         if (s.post_cnt == s.con2[TRIGGER_POSTSCALE_LSB+:4]) begin
            n.trig = 1'b1;
            n.post_cnt = 4'h0;
            ev[EV_TRIGGER] = 1'b1;
         end else begin
            n.post_cnt = s.post_cnt + 4'h1;
         end
      end

      // output pins
      for (int k = 0; k < PAIRS; k++) begin
         act[2*k+1] = ({1'b0, s.cnt} < {1'b0, s.duty_act[k][15:1]});
         act[2*k] = !act[2*k+1];
      end
      for (int i = 0; i < 2*PAIRS; i++) begin
         if (!s.ovd[OVERRIDE_ENABLE_LSB+i]) begin
            act[i] = s.ovd[OVERRIDE_VALUE_LSB+i];
         end
         if (s.fault_act && s.fltcon[FAULT_PAIR_ENABLE_LSB+i/2]) begin
            act[i] = s.fltcon[FAULT_STATE_BITS_LSB+i];
         end
         if (i % 2 == 1) begin
            n.pin_lvl[i] = HIGH_SIDE_POLARITY ? act[i] : !act[i];
         end else begin
            n.pin_lvl[i] = LOW_SIDE_POLARITY ? act[i] : !act[i];
         end
      end

      // bus writes other than status clears land after hardware updates so software wins
      clr = 3'h0;
      if (wr) begin
         case (idx)
            IDX_TIME_BASE_CONTROL: n.tbcon = merge(s.tbcon, wd, AVS_BYTEENABLE[1:0]);
            IDX_TIME_BASE_COUNTER: begin
               n.cnt = 15'(merge({s.dir, s.cnt}, wd, AVS_BYTEENABLE[1:0]));
            end
            IDX_TIME_BASE_PERIOD: begin
               n.per_buf = 15'(merge({1'b0, s.per_buf}, wd, AVS_BYTEENABLE[1:0]));
            end
            IDX_TRIGGER_COMPARE: begin
               n.cmp = merge(s.cmp, wd, AVS_BYTEENABLE[1:0]);
               n.post_cnt = 4'h0;
            end
            IDX_OUTPUT_CONTROL_ONE: n.con1 = merge(s.con1, wd, AVS_BYTEENABLE[1:0]);
            IDX_OUTPUT_CONTROL_TWO: n.con2 = merge(s.con2, wd, AVS_BYTEENABLE[1:0]);
            IDX_DEAD_TIME_CONTROL: n.dtcon = merge(s.dtcon, wd, AVS_BYTEENABLE[1:0]);
            IDX_FAULT_CONTROL: n.fltcon = merge(s.fltcon, wd, AVS_BYTEENABLE[1:0]);
            IDX_MANUAL_OVERRIDE_CONTROL: n.ovd = merge(s.ovd, wd, AVS_BYTEENABLE[1:0]);
            IDX_DUTY_CYCLE_ONE: n.duty_buf[0] = merge(s.duty_buf[0], wd, AVS_BYTEENABLE[1:0]);
            IDX_DUTY_CYCLE_TWO: n.duty_buf[1] = merge(s.duty_buf[1], wd, AVS_BYTEENABLE[1:0]);
            IDX_DUTY_CYCLE_THREE: n.duty_buf[2] = merge(s.duty_buf[2], wd, AVS_BYTEENABLE[1:0]);
            IDX_EVENT_STATUS: clr = AVS_BYTEENABLE[0] ? wd[2:0] : 3'h0;
            IDX_EVENT_MASK: n.mask = AVS_BYTEENABLE[0] ? wd[2:0] : s.mask;
            default: clr = 3'h0;
         endcase
      end
      // an event in the clearing cycle beats the clear, even on a set bit
      if (fault_fell) begin
         ev[EV_FAULT] = 1'b1;
      end
      n.status = (s.status & ~clr) | ev;

      // reads take one wait cycle, data registered
      case (idx)
         IDX_TIME_BASE_CONTROL: rd_mux = s.tbcon;
         IDX_TIME_BASE_COUNTER: rd_mux = {s.dir, s.cnt};
         IDX_TIME_BASE_PERIOD: rd_mux = {1'b0, s.per_buf};
         IDX_TRIGGER_COMPARE: rd_mux = s.cmp;
         IDX_OUTPUT_CONTROL_ONE: rd_mux = s.con1;
         IDX_OUTPUT_CONTROL_TWO: rd_mux = s.con2;
         IDX_DEAD_TIME_CONTROL: rd_mux = s.dtcon;
         IDX_FAULT_CONTROL: rd_mux = s.fltcon;
         IDX_MANUAL_OVERRIDE_CONTROL: rd_mux = s.ovd;
         IDX_DUTY_CYCLE_ONE: rd_mux = s.duty_buf[0];
         IDX_DUTY_CYCLE_TWO: rd_mux = s.duty_buf[1];
         IDX_DUTY_CYCLE_THREE: rd_mux = s.duty_buf[2];
         IDX_EVENT_STATUS: rd_mux = {13'h0000, s.status};
         IDX_EVENT_MASK: rd_mux = {13'h0000, s.mask};
         default: rd_mux = 16'h0000;
      endcase
      n.rvalid = AVS_READ && !s.rvalid;
      if (AVS_READ && !s.rvalid) begin
         n.rdata = {16'h0000, rd_mux};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         s <= '0;
         s.tbcon <= RST_TIME_BASE_CONTROL;
         s.con1 <= RST_OUTPUT_CONTROL_ONE;
         s.con2 <= RST_OUTPUT_CONTROL_TWO;
         s.fltcon <= RST_FAULT_CONTROL;
         s.ovd <= RST_MANUAL_OVERRIDE_CONTROL;
         s.sync1 <= SYNC_RESET_LEVEL;
         s.sync2 <= SYNC_RESET_LEVEL;
         s.sync3 <= SYNC_RESET_LEVEL;
         s.post_cnt <= 4'h0;
      end else begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // writes never wait; a read waits one cycle for registered data
   assign AVS_WAITREQUEST = AVS_READ && !s.rvalid;
   assign AVS_READDATA = s.rdata;
   assign ADC_TRIGGER = s.trig;
   assign IRQ = |(s.status & s.mask);
   assign WAKE = SLEEP && s.status[EV_FAULT];
   assign PWM_OUT = s.pin_lvl;
   for (genvar k = 0; k < PAIRS; k++) begin : g_oe
      assign PWM_OE[2*k+1] = s.con1[PEN_HIGH_LSB+k];
      assign PWM_OE[2*k] = s.con1[PEN_LOW_LSB+k];
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RSTN);

   sequence fault_edge_s;
      $fell(s.sync2);
   endsequence
   sequence fault_held_s;
      !s.sync2 && en_any;
   endsequence
   sequence fault_clear_s;
      s.fault_act && en_any && s.sync2 && boundary;
   endsequence

   sync_depth_a: assert property (fault_edge_s |-> $past(FAULT_INPUT_N, 2) == 1'b0)
      else $error("fault synchroniser not two stages");
   fault_force_a: assert property (fault_held_s |=> s.fault_act)
      else $error("fault did not force outputs");
   latch_hold_a: assert property (s.fault_act && en_any && !cycle_mode && s.status[EV_FAULT]
         |=> s.fault_act)
      else $error("latched fault released with flag set");
   release_bound_a: assert property ($fell(s.fault_act) && $past(en_any)
         |-> $past(boundary) && $past(s.sync2))
      else $error("fault released off boundary");
   fault_level_a: assert property (s.fault_act && s.fltcon[0] && s.fltcon[FAULT_STATE_BITS_LSB+1]
         |=> PWM_OUT[1] == HIGH_SIDE_POLARITY)
      else $error("fault state level wrong on high pin");
   no_enable_a: assert property (!en_any |=> !s.fault_act)
      else $error("fault acted with no pair enabled");
   lock_freeze_a: assert property (lock |=> $stable(s.duty_act) && $stable(s.per_act))
      else $error("buffer loaded while locked");
   trig_width_a: assert property (ADC_TRIGGER |=> !ADC_TRIGGER)
      else $error("trigger wider than one clock");
   trig_cause_a: assert property (ADC_TRIGGER |-> $past(s.cnt) == $past(s.cmp[14:0])
         && (!$past(centre) || $past(s.dir) == $past(s.cmp[TRIGGER_DIRECTION_BIT])))
      else $error("trigger without counter match");
   post_clear_a: assert property (AVS_WRITE && idx == IDX_TRIGGER_COMPARE
         |=> s.post_cnt == 4'h0)
      else $error("postscaler not cleared by compare write");
   idle_halt_a: assert property (IDLE && s.tbcon[IDLE_STOP_BIT] && !AVS_WRITE
         |=> $stable(s.cnt))
      else $error("counter moved in idle stop");
   sleep_wake_a: assert property (SLEEP ##0 fault_edge_s ##1 SLEEP |-> WAKE)
      else $error("no wake on fault in sleep");

   // release, load and trigger timing
   latch_release_a: assert property (fault_clear_s ##0 (!cycle_mode && !s.status[EV_FAULT])
         |=> !s.fault_act)
      else $error("latched fault held after both release conditions");
   cycle_release_a: assert property (fault_clear_s ##0 cycle_mode |=> !s.fault_act)
      else $error("cycle fault held after pin release");
   centre_bound_a: assert property (fault_clear_s ##0 (cycle_mode && centre && at_per)
         |=> !s.fault_act)
      else $error("period match not taken as boundary");
   flag_set_a: assert property (fault_edge_s |=> s.status[EV_FAULT])
      else $error("fault flag not set on falling input");
   low_level_a: assert property (s.fault_act && s.fltcon[FAULT_PAIR_ENABLE_LSB]
         && !s.fltcon[FAULT_STATE_BITS_LSB] |=> PWM_OUT[0] == !LOW_SIDE_POLARITY)
      else $error("fault inactive level wrong on low pin");
   per_load_a: assert property (!lock && !run |=> s.per_act == $past(s.per_buf))
      else $error("period not loaded while stopped and unlocked");
   duty_load_a: assert property (!lock && run && at_zero
         |=> s.duty_act == $past(s.duty_buf))
      else $error("duty not loaded at zero while unlocked");
   trig_fire_a: assert property (run && !centre && s.cnt == s.cmp[14:0] && !s.trig
         && s.post_cnt == s.con2[TRIGGER_POSTSCALE_LSB+:4] |=> ADC_TRIGGER)
      else $error("compare match at postscale end gave no trigger");
   post_zero_a: assert property (ADC_TRIGGER |-> s.post_cnt == 4'h0)
      else $error("postscaler not restarted after trigger");
   dir_block_a: assert property (run && centre && s.dir != s.cmp[TRIGGER_DIRECTION_BIT]
         |=> !ADC_TRIGGER)
      else $error("trigger in the wrong count direction");
   idle_run_a: assert property (s.tbcon[TIME_BASE_ON_BIT] && !s.tbcon[IDLE_STOP_BIT]
         && mode == MODE_FREE && s.cnt < s.per_act && !AVS_WRITE
         |=> s.cnt == $past(s.cnt) + 15'h0001)
      else $error("time base stopped without idle stop");
endmodule

// file: inc/motor_pwm_pkg.sv
// constants shared by the motor pwm fault and trigger block
package motor_pwm_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_TIME_BASE_CONTROL = 10'h1c0;
   localparam logic [9:0] IDX_TIME_BASE_COUNTER = 10'h1c2;
   localparam logic [9:0] IDX_TIME_BASE_PERIOD = 10'h1c4;
   localparam logic [9:0] IDX_TRIGGER_COMPARE = 10'h1c6;
   localparam logic [9:0] IDX_OUTPUT_CONTROL_ONE = 10'h1c8;
   localparam logic [9:0] IDX_OUTPUT_CONTROL_TWO = 10'h1ca;
   localparam logic [9:0] IDX_DEAD_TIME_CONTROL = 10'h1cc;
   localparam logic [9:0] IDX_FAULT_CONTROL = 10'h1d0;
   localparam logic [9:0] IDX_MANUAL_OVERRIDE_CONTROL = 10'h1d4;
   localparam logic [9:0] IDX_DUTY_CYCLE_ONE = 10'h1d6;
   localparam logic [9:0] IDX_DUTY_CYCLE_TWO = 10'h1d8;
   localparam logic [9:0] IDX_DUTY_CYCLE_THREE = 10'h1da;
   localparam logic [9:0] IDX_EVENT_STATUS = 10'h1dc;
   localparam logic [9:0] IDX_EVENT_MASK = 10'h1de;

   // reset values
   localparam logic [15:0] RST_TIME_BASE_CONTROL = 16'h0000;
   localparam logic [15:0] RST_OUTPUT_CONTROL_ONE = 16'h0077;
   localparam logic [15:0] RST_OUTPUT_CONTROL_TWO = 16'h0000;
   localparam logic [15:0] RST_FAULT_CONTROL = 16'h0000;
   localparam logic [15:0] RST_MANUAL_OVERRIDE_CONTROL = 16'h3f00;
   localparam logic [15:0] RST_ZERO16 = 16'h0000;

   // field positions
   localparam int TIME_BASE_ON_BIT = 15;
   localparam int IDLE_STOP_BIT = 13;
   localparam int TB_MODE_LSB = 0;
   localparam int TRIGGER_DIRECTION_BIT = 15;
   localparam int UPDATE_LOCK_BIT = 0;
   localparam int TRIGGER_POSTSCALE_LSB = 8;
   localparam int FAULT_MODE_SELECT_BIT = 7;
   localparam int FAULT_PAIR_ENABLE_LSB = 0;
   localparam int FAULT_STATE_BITS_LSB = 8;
   localparam int OVERRIDE_ENABLE_LSB = 8;
   localparam int OVERRIDE_VALUE_LSB = 0;
   localparam int PEN_HIGH_LSB = 4;
   localparam int PEN_LOW_LSB = 0;

   // event status bits
   localparam int EV_FAULT = 0;
   localparam int EV_TRIGGER = 1;
   localparam int EV_PERIOD = 2;

   // time base modes
   localparam logic [1:0] MODE_FREE = 2'h0;
   localparam logic [1:0] MODE_UPDOWN = 2'h1;
   localparam logic [1:0] MODE_SINGLE = 2'h2;
   localparam logic [1:0] MODE_DOUBLE = 2'h3;

   // synchroniser idles at the released (high) level
   localparam logic SYNC_RESET_LEVEL = 1'b1;
endpackage

// file: verif/fault_source_model.sv
// far side model: fault source with prompt or slow release, a/d trigger counter
module fault_source_model (
   input wire logic clk,
   input wire logic fault_req,
   input wire logic slow,
   input wire logic trig_pulse,
   output logic fault_n,
   output int trig_seen
);
   timeunit 1ns;
   timeprecision 1ns;
   int hold;
   ////////////////////////////////////////////////////////////
   initial begin
      fault_n = 1'b1;
      trig_seen = 0;
      hold = 0;
   end
   // slow release keeps the pin low a few cycles after the request drops
   always @(posedge clk) begin
      if (trig_pulse === 1'b1) begin
         trig_seen <= trig_seen + 1;
      end
      if (fault_req) begin
         fault_n <= 1'b0;
         hold <= slow ? 5 : 0;
      end else if (hold > 0) begin
         hold <= hold - 1;
      end else begin
         // released: the pull-up takes the line high
         fault_n <= 1'b1;
      end
   end
endmodule

// file: verif/motor_pwm_fault_and_trigger_test.sv
// self-checking bench for the motor pwm fault and trigger block
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module motor_pwm_fault_and_trigger_test import motor_pwm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rstn, rd_en, wr_en, waitreq, hp, lp, sleep, idle, fault_req, slow;
   logic trig, irq, wake, fault_n;
   logic [11:0] addr;
   logic [31:0] wdata, rdata, r32;
   logic [3:0] be;
   logic [5:0] pwm, oe, fstate, base;
   logic [15:0] rd;
   int err_total, n_tests, seed, trig_seen, g, t0;
   int ratios[2] = '{1, 16};
   ////////////////////////////////////////////////////////////
   motor_pwm_fault_trigger u_dut (.CLK(clk), .RSTN(rstn), .AVS_ADDRESS(addr),
      .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata),
      .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
      .FAULT_INPUT_N(fault_n), .HIGH_SIDE_POLARITY(hp), .LOW_SIDE_POLARITY(lp),
      .SLEEP(sleep), .IDLE(idle), .PWM_OUT(pwm), .PWM_OE(oe), .ADC_TRIGGER(trig),
      .IRQ(irq), .WAKE(wake));
   fault_source_model u_src (.clk(clk), .fault_req(fault_req), .slow(slow),
      .trig_pulse(trig), .fault_n(fault_n), .trig_seen(trig_seen));
   ////////////////////////////////////////////////////////////
   function automatic logic [5:0] lvl(logic [5:0] act);
      for (int i = 0; i < 6; i++) begin
         lvl[i] = ((i % 2) ? hp : lp) ? act[i] : !act[i];
      end
   endfunction
   function automatic logic [15:0] rst_of(int a);
      if (a == int'(IDX_OUTPUT_CONTROL_ONE)) begin
         return RST_OUTPUT_CONTROL_ONE;
      end
      if (a == int'(IDX_MANUAL_OVERRIDE_CONTROL)) begin
         return RST_MANUAL_OVERRIDE_CONTROL;
      end
      return 16'h0000;
   endfunction
   // request held until waitrequest is sampled low at a rising edge, then released
   task automatic bus(input logic wr, input logic [9:0] idx, input logic [15:0] d);
      @(posedge clk);
      addr <= {idx, 2'b00};
      rd_en <= !wr;
      wr_en <= wr;
      wdata <= {16'h0000, d};
      do begin
         @(posedge clk);
      end while (waitreq !== 1'b0);
      rd = rdata[15:0];
      rd_en <= 1'b0;
      wr_en <= 1'b0;
   endtask
   task automatic pin(input logic req, input int n);
      @(posedge clk);
      fault_req <= req;
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic trig_gap();
      while (trig !== 1'b1) @(negedge clk);
      @(negedge clk);
      `CHK("trigger width", 1'b0, trig)
      g = 1;
      while (trig !== 1'b1) begin
         @(negedge clk);
         g++;
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // whole run is well under two thousand cycles
   initial begin
      repeat (6000) @(posedge clk);
      err_total++;
      give_verdict();
   end
   initial begin
      {rstn, rd_en, wr_en, sleep, idle, fault_req, slow} = '0;
      addr = 12'h000;
      wdata = 32'h0000_0000;
      be = 4'hf;
      seed = 32'he89c_6563;
      r32 = $random(seed);
      hp = r32[0];
      lp = r32[1];
      fstate = r32[7:2];
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      for (int a = 'h1c0; a <= 'h1de; a += 2) begin
         bus(1'b0, a[9:0], 16'h0000);
         `CHK("reset value", rst_of(a), rd)
      end
      `CHK("pin enables", 6'h3f, oe)
      base = lvl(6'b010101);
      `CHK("normal pins", base, pwm)
      // latched mode, prompt release, flag cleared last
      bus(1'b1, IDX_EVENT_MASK, 16'h0001);
      bus(1'b1, IDX_FAULT_CONTROL, {2'b00, fstate, 8'h07});
      sleep <= 1'b1;
      pin(1'b1, 7);
      `CHK("latched fault", lvl(fstate), pwm)
      `CHK("fault irq", 1'b1, irq)
      `CHK("wake", 1'b1, wake)
      @(posedge clk);
      sleep <= 1'b0;
      pin(1'b0, 8);
      `CHK("held while flagged", lvl(fstate), pwm)
      bus(1'b1, IDX_EVENT_STATUS, 16'h0001);
      pin(1'b0, 4);
      `CHK("latched release", base, pwm)
      `CHK("irq cleared", 1'b0, irq)
      // flag cleared while the slow source still holds the pin low
      slow <= 1'b1;
      pin(1'b1, 7);
      bus(1'b1, IDX_EVENT_STATUS, 16'h0001);
      pin(1'b0, 3);
      `CHK("early clear", lvl(fstate), pwm)
      pin(1'b0, 12);
      `CHK("late release", base, pwm)
      // cycle by cycle: no flag clearing needed
      bus(1'b1, IDX_FAULT_CONTROL, {2'b00, fstate, 8'h87});
      pin(1'b1, 7);
      `CHK("cycle fault", lvl(fstate), pwm)
      pin(1'b0, 14);
      `CHK("cycle release", base, pwm)
      bus(1'b1, IDX_EVENT_STATUS, 16'h0001);
      // no pair enabled: pins untouched, flag still raised
      bus(1'b1, IDX_FAULT_CONTROL, {2'b00, 6'h3f, 8'h00});
      pin(1'b1, 8);
      `CHK("no pair enabled", base, pwm)
      `CHK("flag irq", 1'b1, irq)
      bus(1'b1, IDX_EVENT_MASK, 16'h0000);
      @(negedge clk);
      `CHK("masked irq", 1'b0, irq)
      pin(1'b0, 14);
      bus(1'b1, IDX_EVENT_STATUS, 16'h0001);
      // update lock
      bus(1'b1, IDX_OUTPUT_CONTROL_TWO, 16'h0001);
      bus(1'b1, IDX_DUTY_CYCLE_ONE, 16'hfffe);
      pin(1'b0, 3);
      `CHK("locked duty", base, pwm)
      bus(1'b1, IDX_OUTPUT_CONTROL_TWO, 16'h0000);
      pin(1'b0, 3);
      `CHK("unlocked duty", lvl(6'b010110), pwm)
      // free running trigger, postscale ends
      bus(1'b1, IDX_TIME_BASE_PERIOD, 16'h0007);
      foreach (ratios[i]) begin
         bus(1'b1, IDX_OUTPUT_CONTROL_TWO, {4'h0, 4'(ratios[i] - 1), 8'h00});
         bus(1'b1, IDX_TRIGGER_COMPARE, {13'h0000, r32[10:8]});
         bus(1'b1, IDX_TIME_BASE_CONTROL, 16'h8000);
         trig_gap();
         `CHK("free gap", ratios[i] * 8, g)
         bus(1'b1, IDX_TIME_BASE_CONTROL, 16'h0000);
      end
      // up/down, then double update: one match per full cycle in the chosen direction
      bus(1'b1, IDX_OUTPUT_CONTROL_TWO, 16'h0000);
      for (int d = 0; d < 2; d++) begin
         bus(1'b1, IDX_TRIGGER_COMPARE, {d[0], 12'h000, {1'b0, r32[12:11]} + 3'd1});
         bus(1'b1, IDX_TIME_BASE_CONTROL, {14'h2000, d[0], 1'b1});
         trig_gap();
         `CHK("updown gap", 14, g)
         bus(1'b1, IDX_TIME_BASE_CONTROL, 16'h0000);
      end
      // idle stop halts triggers only while idle
      bus(1'b1, IDX_TIME_BASE_CONTROL, 16'ha000);
      idle <= 1'b1;
      repeat (4) @(posedge clk);
      t0 = trig_seen;
      repeat (40) @(posedge clk);
      `CHK("idle halted", t0, trig_seen)
      idle <= 1'b0;
      repeat (40) @(posedge clk);
      `CHK("idle resumed", 1'b1, trig_seen > t0)
      give_verdict();
   end
endmodule
